/* include/adc_seq_pkg.sv */
package adc_seq_pkg;

  // ---------------------------------------------------------------
  // control byte layout, first bit received is the msb
  // ---------------------------------------------------------------
  localparam int CTRL_BITS = 8;
  localparam logic [3:0] TRACK_BIT_NUM = 4'h6; // tracking starts after this bit
  localparam logic [3:0] HOLD_BIT_NUM = 4'h8; // hold and convert after this bit
  localparam int EARLY_SEL_POS = 2; // select field lsb after six bits
  localparam int EARLY_SGL_POS = 0; // input config bit after six bits

  // power_mode_hi/lo encodings that pick the conversion clock
  localparam logic [1:0] PMODE_EXT_CLK = 2'h3;
  localparam logic [1:0] PMODE_INT_CLK = 2'h2;

  // ---------------------------------------------------------------
  // converter sizes and timing
  // ---------------------------------------------------------------
  localparam int RESULT_W = 8;
  localparam int CHANNELS = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [RESULT_W-1:0] SAR_FIRST_TRIAL = 8'h80;
  localparam logic [1:0] STRB_PERIODS = 2'h2; // external mode strobe length
  localparam int CLK_PERIOD_NS = 40;
  localparam int INT_STEP_NS = 640; // internal clock period per sar step
  localparam int INT_STEP_CYC_I = (INT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] INT_STEP_CYC = 8'(INT_STEP_CYC_I);

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic start;
    logic [2:0] chan_sel; // channel_select_msb .. channel_select_lsb
    logic polarity_select; // 1 = unipolar
    logic input_config_select; // 1 = single-ended
    logic power_mode_hi;
    logic power_mode_lo;
  } ctrl_t;

  typedef struct packed {
    logic [CHANNELS-1:0] pos; // one-hot switch to positive sampling node
    logic [CHANNELS-1:0] neg; // one-hot switch to negative sampling node
    logic com; // common input to negative sampling node
  } mux_t;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_CTRL,
    SEQ_CONV,
    SEQ_STRB
  } seq_state_t;

endpackage : adc_seq_pkg

/* design/result_fifo.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// synchronous fifo, valid/ready on both sides
// ---------------------------------------------------------------
module result_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  wire do_push = in_valid_i && in_ready_o;
  wire do_pop = out_valid_o && out_ready_i;

  // full and empty come straight from the occupancy count
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];

  // storage has no reset; only pointers and count matter
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

endmodule : result_fifo

/* design/serial_adc_conversion_sequencer.sv */
`timescale 1ns/10ps
module serial_adc_conversion_sequencer (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // serial link pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic conversion_strobe_out_o,
  output logic conversion_strobe_oe_o,
  // three-level shutdown detector outputs
  input wire logic shutdown_low_i,
  input wire logic shutdown_high_i,
  // power control
  output logic full_power_down_o,
  output logic reference_power_down_o,
  output logic [1:0] power_mode_o,
  // analog front end
  input wire logic comparator_i,
  output logic [adc_seq_pkg::RESULT_W-1:0] dac_code_o,
  output adc_seq_pkg::mux_t analog_channels_o,
  output logic hold_capacitor_track_o,
  output logic hold_capacitor_to_neg_o,
  output logic bipolar_o,
  // status
  output logic result_overflow_stall_o
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] cs_sync;
  logic [1:0] sclk_sync;
  logic [1:0] din_sync;
  logic [1:0] cmp_sync;
  logic [1:0] sdl_sync;
  logic [1:0] sdh_sync;
  logic sclk_prev;

  // two flops per pin; only the second stage feeds any logic
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cs_sync <= 2'h3;
      sclk_sync <= 2'h0;
      din_sync <= 2'h0;
      cmp_sync <= 2'h0;
      sdl_sync <= 2'h0;
      sdh_sync <= 2'h0;
      sclk_prev <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[0], cs_n_i};
      sclk_sync <= {sclk_sync[0], sclk_i};
      din_sync <= {din_sync[0], din_i};
      cmp_sync <= {cmp_sync[0], comparator_i};
      sdl_sync <= {sdl_sync[0], shutdown_low_i};
      sdh_sync <= {sdh_sync[0], shutdown_high_i};
      sclk_prev <= sclk_sync[1];
    end
  end

  wire cs_n = cs_sync[1];
  wire din = din_sync[1];
  wire cmp = cmp_sync[1];
  // edges only count while selected, so stray clocks are harmless
  wire sclk_rise = sclk_sync[1] && !sclk_prev && !cs_n;
  wire sclk_fall = !sclk_sync[1] && sclk_prev && !cs_n;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // channel switch pattern for a select field and input configuration
  function automatic adc_seq_pkg::mux_t chan_decode(input logic [2:0] sel,
                                                    input logic single);
    adc_seq_pkg::mux_t m;
    logic [2:0] pos_idx;
    logic [2:0] neg_idx;
    m = '0;
    if (single) begin
      pos_idx = {sel[1], sel[0], sel[2]};
      neg_idx = 3'h0;
      m.pos[pos_idx] = 1'b1;
      m.com = 1'b1;
    end else begin
      pos_idx = {sel[1], sel[0], sel[2]};
      neg_idx = {sel[1], sel[0], !sel[2]};
      m.pos[pos_idx] = 1'b1;
      m.neg[neg_idx] = 1'b1;
    end
    return m;
  endfunction : chan_decode

  // one successive approximation decision on the current trial bit
  function automatic logic [adc_seq_pkg::RESULT_W-1:0] sar_keep(
      input logic [adc_seq_pkg::RESULT_W-1:0] trial,
      input logic [adc_seq_pkg::RESULT_W-1:0] mask,
      input logic above);
    return above ? trial : (trial ^ mask);
  endfunction : sar_keep

  // ---------------------------------------------------------------
  // sequencer registers
  // ---------------------------------------------------------------
  adc_seq_pkg::seq_state_t state;
  adc_seq_pkg::ctrl_t ctrl_sh;
  logic [3:0] bit_cnt;
  logic ext_mode;
  logic [adc_seq_pkg::RESULT_W-1:0] trial;
  logic [adc_seq_pkg::RESULT_W-1:0] mask;
  logic [7:0] tick_cnt;
  logic [1:0] strb_cnt;
  logic strobe;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [adc_seq_pkg::RESULT_W-1:0] fifo_out_data;

  // ---------------------------------------------------------------
  // conversion decode
  // ---------------------------------------------------------------
  // after six bits the select field and config bit already sit in the shifter
  wire [2:0] early_sel = ctrl_sh[adc_seq_pkg::EARLY_SEL_POS +: 3];
  wire early_single = ctrl_sh[adc_seq_pkg::EARLY_SGL_POS];
  wire [1:0] next_pmode = {ctrl_sh[0], din};
  wire track_point = sclk_fall && state == adc_seq_pkg::SEQ_CTRL
                     && bit_cnt == adc_seq_pkg::TRACK_BIT_NUM;
  wire hold_point = sclk_fall && state == adc_seq_pkg::SEQ_CTRL
                    && bit_cnt == adc_seq_pkg::HOLD_BIT_NUM;
  wire int_tick = (tick_cnt == adc_seq_pkg::INT_STEP_CYC - 8'h01);
  // external mode steps on the host clock, internal on the local divider
  wire sar_step = state == adc_seq_pkg::SEQ_CONV && (ext_mode ? sclk_fall : int_tick);
  wire last_step = sar_step && mask == 8'h01;
  wire [adc_seq_pkg::RESULT_W-1:0] kept = sar_keep(trial, mask, cmp);
  // a full result fifo stalls the last decision instead of losing a code
  wire conv_done = last_step && fifo_in_ready;

  // ---------------------------------------------------------------
  // control byte reception and conversion sequence
  // ---------------------------------------------------------------
  // zeros before the start bit never leave idle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= adc_seq_pkg::SEQ_IDLE;
      ctrl_sh <= '0;
      bit_cnt <= 4'h0;
      ext_mode <= 1'b0;
      strb_cnt <= 2'h0;
    end else begin
      case (state)
        adc_seq_pkg::SEQ_IDLE: begin
          if (sclk_rise && din) begin
            ctrl_sh <= adc_seq_pkg::ctrl_t'(8'h01);
            bit_cnt <= 4'h1;
            state <= adc_seq_pkg::SEQ_CTRL;
          end
        end
        adc_seq_pkg::SEQ_CTRL: begin
          if (cs_n) begin
            state <= adc_seq_pkg::SEQ_IDLE;
          end else if (sclk_rise && bit_cnt != adc_seq_pkg::HOLD_BIT_NUM) begin
            ctrl_sh <= {ctrl_sh[6:0], din};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == adc_seq_pkg::HOLD_BIT_NUM - 4'h1) begin
              ext_mode <= (next_pmode == adc_seq_pkg::PMODE_EXT_CLK);
            end
          end else if (hold_point) begin
            state <= adc_seq_pkg::SEQ_CONV;
          end
        end
        adc_seq_pkg::SEQ_CONV: begin
          if (conv_done) begin
            strb_cnt <= 2'h0;
            state <= ext_mode ? adc_seq_pkg::SEQ_STRB : adc_seq_pkg::SEQ_IDLE;
          end
        end
        adc_seq_pkg::SEQ_STRB: begin
          if (sclk_fall) begin
            strb_cnt <= strb_cnt + 2'h1;
            if (strb_cnt == adc_seq_pkg::STRB_PERIODS - 2'h1) begin
              state <= adc_seq_pkg::SEQ_IDLE;
            end
          end
        end
        default: begin
          state <= adc_seq_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // successive approximation register and internal step divider
  // ---------------------------------------------------------------
  // the dac always shows the code under trial
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      trial <= 8'h00;
      mask <= 8'h00;
      tick_cnt <= 8'h00;
    end else if (hold_point) begin
      trial <= adc_seq_pkg::SAR_FIRST_TRIAL;
      mask <= adc_seq_pkg::SAR_FIRST_TRIAL;
      tick_cnt <= 8'h00;
    end else begin
      tick_cnt <= int_tick ? 8'h00 : tick_cnt + 8'h01;
      if (sar_step && !last_step) begin
        trial <= kept | (mask >> 1);
        mask <= mask >> 1;
      end else if (conv_done) begin
        trial <= kept;
        mask <= 8'h00;
      end
    end
  end

  assign dac_code_o = trial;

  // ---------------------------------------------------------------
  // analog switches and track/hold
  // ---------------------------------------------------------------
  // the mux only moves at the tracking point, so acquisition sees one channel
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      analog_channels_o <= '0;
      hold_capacitor_track_o <= 1'b1;
      hold_capacitor_to_neg_o <= 1'b0;
      bipolar_o <= 1'b0;
      power_mode_o <= 2'h0;
    end else if (track_point) begin
      analog_channels_o <= chan_decode(early_sel, early_single);
      hold_capacitor_track_o <= 1'b1;
      hold_capacitor_to_neg_o <= 1'b0;
    end else if (hold_point) begin
      hold_capacitor_track_o <= 1'b0;
      hold_capacitor_to_neg_o <= 1'b1;
      // the whole byte sits in the shifter by now, so read the named fields
      bipolar_o <= !ctrl_sh.polarity_select;
      power_mode_o <= {ctrl_sh.power_mode_hi, ctrl_sh.power_mode_lo};
    end else if (conv_done) begin
      hold_capacitor_track_o <= 1'b1;
      hold_capacitor_to_neg_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // end-of-conversion strobe
  // ---------------------------------------------------------------
  // internal mode idles high; external mode idles low between pulses
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      strobe <= 1'b0;
    end else if (hold_point) begin
      strobe <= 1'b0;
    end else if (conv_done) begin
      strobe <= 1'b1;
    end else if (state == adc_seq_pkg::SEQ_STRB && sclk_fall
                 && strb_cnt == adc_seq_pkg::STRB_PERIODS - 2'h1) begin
      strobe <= 1'b0;
    end else if (state == adc_seq_pkg::SEQ_IDLE && !ext_mode) begin
      strobe <= 1'b1;
    end
  end

  assign conversion_strobe_out_o = strobe;
  assign conversion_strobe_oe_o = ext_mode ? !cs_n : 1'b1;

  // ---------------------------------------------------------------
  // result fifo between converter and output shifter
  // ---------------------------------------------------------------
  logic [adc_seq_pkg::RESULT_W-1:0] out_sh;
  logic [3:0] out_cnt;
  wire sh_load = (out_cnt == 4'h0);

  result_fifo #(
    .WIDTH(adc_seq_pkg::RESULT_W),
    .DEPTH(adc_seq_pkg::FIFO_DEPTH)
  ) u_result_fifo (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_valid_i(last_step),
    .in_ready_o(fifo_in_ready),
    .in_data_i(kept),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(sh_load),
    .out_data_o(fifo_out_data)
  );

  assign result_overflow_stall_o = last_step && !fifo_in_ready;

  // ---------------------------------------------------------------
  // result output shifter
  // ---------------------------------------------------------------
  // shifting waits out the sar and the strobe pulse so the msb follows it
  wire shift_ok = state != adc_seq_pkg::SEQ_CONV
                  && !(state == adc_seq_pkg::SEQ_STRB && strb_cnt == 2'h0);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      out_sh <= 8'h00;
      out_cnt <= 4'h0;
      dout_o <= 1'b0;
    end else if (sh_load && fifo_out_valid) begin
      out_sh <= fifo_out_data;
      out_cnt <= 4'h8;
    end else if (sclk_fall && shift_ok) begin
      if (out_cnt != 4'h0) begin
        dout_o <= out_sh[adc_seq_pkg::RESULT_W-1];
        out_sh <= {out_sh[adc_seq_pkg::RESULT_W-2:0], 1'b0};
        out_cnt <= out_cnt - 4'h1;
      end else begin
        dout_o <= 1'b0; // trailing bits read as zero
      end
    end
  end

  assign dout_oe_o = !cs_n;

  // ---------------------------------------------------------------
  // shutdown decode
  // ---------------------------------------------------------------
  // a floating input asserts neither detector and leaves everything running
  assign full_power_down_o = sdl_sync[1];
  assign reference_power_down_o = sdh_sync[1] && !sdl_sync[1];

endmodule : serial_adc_conversion_sequencer

/* verif/host_link_model.sv */
`timescale 1ns/10ps
// -------------------------------------------------------------
// serial host: select, 320 ns link clock, data out, result in
// -------------------------------------------------------------
module host_link_model (
  // core clock paces every edge
  input wire logic core_clk_i,
  // result wire seen from the device
  input wire logic dout_i,
  input wire logic dout_oe_i,
  // link pins driven by the host
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o
);
  logic toggle = 1'b0;
  logic tx_bit = 1'b0;

  // released data line wiggles so an ignored input cannot pass by luck
  always @(negedge core_clk_i) begin
    toggle <= ~toggle;
  end
  assign din_o = cs_n_o ? toggle : tx_bit;

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
  end

  // change select, then let the sync flops settle
  task automatic select(input logic v);
    @(negedge core_clk_i);
    cs_n_o = v;
    repeat (4) @(negedge core_clk_i);
  endtask : select

  // n clocks, msb first from tx[n-1]; result read just before each fall
  task automatic shift(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      tx_bit = tx[i];
      repeat (4) @(negedge core_clk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge core_clk_i);
      rx = {rx[30:0], dout_oe_i ? dout_i : 1'bx};
      sclk_o = 1'b0;
    end
  endtask : shift
endmodule : host_link_model

/* verif/seq_link_sva.sv */
`timescale 1ns/10ps
// -------------------------------------------------------------
// port checker for the conversion sequencer
// -------------------------------------------------------------
module seq_link_sva (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // link and shutdown inputs
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic shutdown_low_i,
  input wire logic shutdown_high_i,
  // watched outputs
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic conversion_strobe_out_o,
  input wire logic conversion_strobe_oe_o,
  input wire logic full_power_down_o,
  input wire logic reference_power_down_o,
  input wire logic [1:0] power_mode_o,
  input wire logic [adc_seq_pkg::RESULT_W-1:0] dac_code_o,
  input wire adc_seq_pkg::mux_t analog_channels_o,
  input wire logic hold_capacitor_track_o,
  input wire logic hold_capacitor_to_neg_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // strobe stays up two link periods of eight core cycles each
  sequence strobe_two_periods;
    conversion_strobe_out_o [*8] ##1 conversion_strobe_out_o [*8];
  endsequence
  sequence hold_entered;
    (dac_code_o == adc_seq_pkg::SAR_FIRST_TRIAL) && !conversion_strobe_out_o;
  endsequence

  a_dout_released: assert property (cs_n_i [*4] |-> !dout_oe_o)
    else $error("dout driven while select high");
  a_strobe_released: assert property (cs_n_i [*4] ##0
    (power_mode_o == adc_seq_pkg::PMODE_EXT_CLK) |-> !conversion_strobe_oe_o)
    else $error("strobe driven while select high in external mode");
  a_strobe_width: assert property ($rose(conversion_strobe_out_o) &&
    (power_mode_o == adc_seq_pkg::PMODE_EXT_CLK) |-> strobe_two_periods ##1 !conversion_strobe_out_o)
    else $error("external strobe not two link periods");
  a_hold_start: assert property ($rose(hold_capacitor_to_neg_o) |-> ##[0:1] hold_entered)
    else $error("hold without first trial and strobe low");
  a_hold_track_excl: assert property (hold_capacitor_to_neg_o |-> !hold_capacitor_track_o)
    else $error("hold capacitor tracking while converting");
  a_dout_on_fall: assert property ($changed(dout_o) && dout_oe_o && $past(dout_oe_o)
    |-> $past(sclk_i, 6) && !$past(sclk_i, 2))
    else $error("dout moved away from a link clock fall");
  a_full_power_down: assert property ($stable(shutdown_low_i) [*4]
    |-> full_power_down_o == shutdown_low_i)
    else $error("full power down does not follow shutdown low");
  a_ref_power_down: assert property ($stable({shutdown_low_i, shutdown_high_i}) [*4]
    |-> reference_power_down_o == (shutdown_high_i && !shutdown_low_i))
    else $error("reference power down wrong");
  a_pair_adjacent: assert property ((|analog_channels_o.neg) |-> !analog_channels_o.com &&
    analog_channels_o.neg == (((analog_channels_o.pos & 8'h55) << 1) |
    ((analog_channels_o.pos & 8'haa) >> 1)))
    else $error("differential pair not adjacent");
endmodule : seq_link_sva

bind serial_adc_conversion_sequencer seq_link_sva u_sva (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
  .shutdown_low_i(shutdown_low_i), .shutdown_high_i(shutdown_high_i),
  .dout_o(dout_o), .dout_oe_o(dout_oe_o),
  .conversion_strobe_out_o(conversion_strobe_out_o),
  .conversion_strobe_oe_o(conversion_strobe_oe_o),
  .full_power_down_o(full_power_down_o), .reference_power_down_o(reference_power_down_o),
  .power_mode_o(power_mode_o), .dac_code_o(dac_code_o), .analog_channels_o(analog_channels_o),
  .hold_capacitor_track_o(hold_capacitor_track_o),
  .hold_capacitor_to_neg_o(hold_capacitor_to_neg_o));

/* verif/tb_top.sv */
`timescale 1ns/10ps
// -------------------------------------------------------------
// self-checking bench
// -------------------------------------------------------------
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sd_low = 1'b0;
  logic sd_high = 1'b0;
  logic comp = 1'b0;
  logic [7:0] target = 8'h00;
  logic cs_n, sclk, din, dout, dout_oe, strb, strb_oe, fpd, rpd, track, to_neg, bipolar, stall;
  logic [1:0] pmode;
  logic [7:0] dac;
  adc_seq_pkg::mux_t chans;
  int error_cnt = 0;
  int samples_checked = 0;

  always #20 clk = ~clk;
  // analog stand-in: input voltage equals target code
  always @(negedge clk) comp <= (dac <= target);

  serial_adc_conversion_sequencer u_dut (.core_clk_i(clk), .rst_i(rst), .cs_n_i(cs_n),
    .sclk_i(sclk), .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe),
    .conversion_strobe_out_o(strb), .conversion_strobe_oe_o(strb_oe),
    .shutdown_low_i(sd_low), .shutdown_high_i(sd_high), .full_power_down_o(fpd),
    .reference_power_down_o(rpd), .power_mode_o(pmode), .comparator_i(comp),
    .dac_code_o(dac), .analog_channels_o(chans), .hold_capacitor_track_o(track),
    .hold_capacitor_to_neg_o(to_neg), .bipolar_o(bipolar), .result_overflow_stall_o(stall));
  host_link_model u_host (.core_clk_i(clk), .dout_i(dout), .dout_oe_i(dout_oe),
    .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      error_cnt++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask : check

  task automatic tally_and_finish();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // switch pattern expected from the select field
  function automatic adc_seq_pkg::mux_t want_mux(input logic [2:0] sel, input logic sgl);
    adc_seq_pkg::mux_t m;
    m = '0;
    m.pos[{sel[1:0], sel[2]}] = 1'b1;
    if (sgl) begin
      m.com = 1'b1;
    end else begin
      m.neg[{sel[1:0], ~sel[2]}] = 1'b1;
    end
    return m;
  endfunction : want_mux

  // shutdown levels, then a byte cut short by select
  task automatic run_misc();
    logic [31:0] rx;
    for (int k = 0; k < 4; k++) begin
      {sd_high, sd_low} = 2'(k);
      repeat (4) @(negedge clk);
      check(32'({fpd, rpd}), 32'({k == 1 || k == 3, k == 2}));
    end
    {sd_high, sd_low} = 2'h0;
    u_host.select(1'b0);
    u_host.shift(32'hf, 4, rx);
    u_host.select(1'b1);
    check(32'({to_neg, strb}), 32'h1);
  endtask : run_misc

  // internal clock: two leading zeros, then byte 1_011_0_1_10
  task automatic run_internal();
    logic [31:0] rx;
    int n;
    n = 0;
    target = 8'ha5;
    u_host.select(1'b0);
    u_host.shift(32'hb6, 10, rx);
    repeat (6) @(negedge clk);
    check(32'({strb, to_neg}), 32'h1);
    while (strb !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    check(32'({strb, track, to_neg, bipolar}), 32'hd);
    u_host.shift(32'h0, 9, rx);
    check(32'(rx[7:0]), 32'(target));
    u_host.select(1'b1);
    check(32'({dout_oe, strb_oe}), 32'h1);
  endtask : run_internal

  // external clock: every select code, single-ended then differential
  task automatic run_external();
    logic [31:0] rx;
    logic [7:0] ctrl;
    for (int k = 0; k < 16; k++) begin
      ctrl = {1'b1, 3'(k), k[0], ~k[3], adc_seq_pkg::PMODE_EXT_CLK};
      target = 8'(k * 17);
      u_host.select(1'b0);
      fork
        u_host.shift(32'(ctrl) << 18, 26, rx);
        begin
          repeat (80) @(negedge clk);
          check(32'(chans), 32'(want_mux(ctrl[6:4], ctrl[2])));
          check(32'({to_neg, track}), 32'h2);
        end
      join
      check(32'(rx[7:0]), 32'(target));
      check(32'({bipolar, pmode}), 32'({~ctrl[3], ctrl[1:0]}));
      check(32'(stall), 32'h0);
      u_host.select(1'b1);
      check(32'({dout_oe, strb_oe}), 32'h0);
    end
  endtask : run_external

  // watchdog well past the expected run of about 150 microseconds
  initial begin
    #1000000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    run_misc();
    run_internal();
    run_external();
    tally_and_finish();
  end
endmodule : tb_top
